//--- rtl/eism_top.sv
// extended event status and mask registers with interrupt routing
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "eism_map.svh"

module eism_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic soft_rst,
    // register port
    input wire eism_pkg::eism_req_t req,
    output logic [31:0] rdata,
    // event strobes and fifo error cause
    input wire eism_pkg::eism_events_t events,
    input wire logic [3:0] fifo_err_code,
    // group-0 summaries from the group-0 register block
    input wire logic group0_pending,
    input wire logic group0_int_req,
    // interrupt pin and test-mode level
    output logic ext_int,
    output logic direct_register_test_enable
);

    // ************************************************************
    // state
    // ************************************************************
    // bits 1 and 2 never live in status_reg: both are summaries built at read time,
    // so a stale copy can never disagree with the group-0 block or with the stored
    // event bits
    logic [15:0] status_reg;   // stored event bits only
    logic [15:0] status_next;
    logic [15:0] mask_reg;     // enables plus routing bit 2
    logic [15:0] mask_next;
    logic group1_force_reg;    // bit 2 as written in test mode
    logic test_en_reg;         // direct access test bit
    logic [3:0] code_reg;      // last fifo error cause
    logic [31:0] rdata_reg;    // answer one cycle after read
    logic [31:0] rdata_next;
    logic ext_int_reg;
    logic ext_int_next;
    logic [15:0] set_vec;      // this cycle's events at their bits
    logic [15:0] wr_vec;       // write data, event bits only
    logic [15:0] keep_vec;     // bits a plain write leaves set
    logic [15:0] status_view;  // status as software sees it
    logic wr_status;
    logic wr_mask;
    logic wr_diagnostic_test_register;
    logic rd_hit;
    logic group1_summary;
    logic group1_req;

    // ************************************************************
    // helpers
    // ************************************************************
    // one place maps strobes to bit positions, so the set path and the checks
    // below cannot drift apart when a source moves
    // place each strobe at its status position
    function automatic logic [15:0] ev_to_vec(input eism_pkg::eism_events_t e);
        logic [15:0] v;
        v = `EISM_STATUS_RST;
        v[`EISM_B_ASYNC_AVAIL] = e.async_rx_packet_avail;
        v[`EISM_B_ISO_AVAIL] = e.iso_rx_packet_avail;
        v[`EISM_B_TA_AVAIL] = e.transport_a_rx_avail;
        v[`EISM_B_TB_AVAIL] = e.transport_b_rx_avail;
        v[`EISM_B_TA_RELEASE] = e.transport_a_release_hit;
        v[`EISM_B_TB_RELEASE] = e.transport_b_release_hit;
        v[`EISM_B_TB_HDR_LOADED] = e.transport_b_header_loaded;
        v[`EISM_B_FIFO_ERR] = e.host_fifo_access_error;
        v[`EISM_B_OVERLAP_ERR] = e.host_overlapping_op_error;
        v[`EISM_B_ASYNC_PURGE] = e.async_rx_purge;
        v[`EISM_B_ISO_PURGE] = e.iso_rx_purge;
        return v;
    endfunction

    // address match for a strobe
    function automatic logic hit(input logic strobe, input logic [7:0] a,
                                 input logic [7:0] ofs);
        return strobe && (a == ofs);
    endfunction

    // ************************************************************
    // decode
    // ************************************************************
    // each status event has its own strobe
    assign set_vec = ev_to_vec(events) & `EISM_EVENT_BITS;
    // unused positions never reach storage
    assign wr_vec = req.wdata[15:0] & `EISM_EVENT_BITS;
    assign keep_vec = status_reg & ~req.wdata[15:0];
    // exact byte match: a near miss on the address must never clear status,
    // since a lost event cannot be recovered by software
    assign wr_status = hit(req.wr, req.addr, `EISM_OFS_STATUS);
    assign wr_mask = hit(req.wr, req.addr, `EISM_OFS_MASK);
    assign wr_diagnostic_test_register = hit(req.wr, req.addr, `EISM_OFS_DIAGNOSTIC_TEST_REGISTER);
    assign rd_hit = req.rd;

    // ************************************************************
    // status bits
    // ************************************************************
    // set beats clear: an event in the clearing cycle still lands
    // trade-off: software may see a bit again right after clearing it, but
    // an event arriving with the clear is never silently swallowed
    // the same holds for a test-mode load
    always_comb begin
        status_next = status_reg | set_vec;
        if (wr_status) begin
            if (test_en_reg) begin
                // direct load in test mode
                status_next = wr_vec | set_vec;
            end else begin
                // write one to clear, zero leaves alone
                status_next = (status_reg & ~wr_vec) | set_vec;
            end
        end
    end

    // power-up and software reset both clear
    // software reset wins over an event in the same cycle, like power-up,
    // so the block always leaves reset with a clean status word
    always_ff @(posedge clk) begin
        if (!nrst || soft_rst) begin
            status_reg <= `EISM_STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // bit 2 is a summary, writable only in test mode
    // leaving test mode drops the forced value one edge later, so only the first
    // cycle of normal operation can see a summary that no stored bit backs up
    always_ff @(posedge clk) begin
        if (!nrst || soft_rst || !test_en_reg) begin
            group1_force_reg <= 1'b0;
        end else if (wr_status) begin
            group1_force_reg <= req.wdata[`EISM_B_GROUP1];
        end
    end

    // ************************************************************
    // mask register
    // ************************************************************
    // only power-up clears the mask; software reset keeps it
    // bit 1 is reserved and bit 2 is the routing switch, not a source;
    // unused positions are masked off before storage
    always_comb begin
        mask_next = mask_reg;
        if (wr_mask) begin
            mask_next = req.wdata[15:0] & `EISM_MASK_BITS;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mask_reg <= `EISM_MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // ************************************************************
    // diagnostic test bit and fifo error cause
    // ************************************************************
    // only the direct-access test bit of the diagnostic register lives here;
    // its other bits read zero, and the test bit is driven out as a level
    // for the neighbouring register blocks
    always_ff @(posedge clk) begin
        if (!nrst || soft_rst) begin
            test_en_reg <= `EISM_DIAGNOSTIC_TEST_REGISTER_RST;
        end else if (wr_diagnostic_test_register) begin
            test_en_reg <= req.wdata[`EISM_B_DIAGNOSTIC_TEST_REGISTER_TEST];
        end
    end

    // cause is caught with the error strobe itself
    // the code input is only valid beside its strobe, so it is never sampled
    // at any other time; a later error overwrites the earlier cause
    always_ff @(posedge clk) begin
        if (!nrst || soft_rst) begin
            code_reg <= `EISM_CODE_RST;
        end else if (events.host_fifo_access_error) begin
            code_reg <= fifo_err_code;
        end
    end

    // ************************************************************
    // summaries and interrupt
    // ************************************************************
    // the summary ignores the mask on purpose: software polling status must
    // see pending work even while the pin is masked off
    // any stored extended bit raises the summary
    assign group1_summary = (|status_reg) | group1_force_reg;
    // masked-off bits drop out here
    assign group1_req = |(status_reg & mask_reg & `EISM_EVENT_BITS);

    // view that software reads; bit 1 follows group 0
    always_comb begin
        status_view = status_reg;
        status_view[`EISM_B_GROUP0] = group0_pending;
        status_view[`EISM_B_GROUP1] = group1_summary;
    end

    // both groups reach the pin, group 1 gated by mask bit 2
    // registered so the pin cannot glitch on decode; costs one cycle
    // software reset leaves the pin flop alone; it follows the cleared status
    // one edge later through the normal path
    always_comb begin
        ext_int_next = group0_int_req || (mask_reg[`EISM_B_GROUP1] && group1_req);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_int_reg <= 1'b0;
        end else begin
            ext_int_reg <= ext_int_next;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    // unmapped offsets answer zero
    // the view is decoded every cycle but only captured on a read strobe;
    // reserved bits of every register come back as zero
    always_comb begin
        rdata_next = 32'h00000000;
        unique case (req.addr)
            `EISM_OFS_STATUS: begin
                rdata_next[15:0] = status_view;
            end
            `EISM_OFS_MASK: begin
                rdata_next[15:0] = mask_reg;
            end
            `EISM_OFS_DIAGNOSTIC_TEST_REGISTER: begin
                rdata_next[`EISM_B_DIAGNOSTIC_TEST_REGISTER_TEST] = test_en_reg;
            end
            `EISM_OFS_FIFO_MISC: begin
                rdata_next[`EISM_CODE_MSB:`EISM_CODE_LSB] = code_reg;
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    // clearing between reads keeps a stale word off the shared read bus
    always_ff @(posedge clk) begin
        if (!nrst || !rd_hit) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign ext_int = ext_int_reg;
    assign direct_register_test_enable = test_en_reg;

    // ************************************************************
    // checks
    // ************************************************************
    // all checks run on the single block clock; power-up reset disables them,
    // software reset does not, so the checks guard that path themselves
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_plain_status_write;
        wr_status && !test_en_reg && !soft_rst;
    endsequence

    sequence s_test_status_write;
        wr_status && test_en_reg && !soft_rst;
    endsequence

    sequence s_routed_pending;
        mask_reg[`EISM_B_GROUP1] && group1_req;
    endsequence

    chk_w1c_clears: assert property (
        s_plain_status_write |=>
            (status_reg & $past(wr_vec) & ~$past(set_vec)) == 16'h0000)
        else $error("written one did not clear status bit");

    chk_w0_keeps: assert property (
        s_plain_status_write |=> (status_reg & $past(keep_vec)) == $past(keep_vec))
        else $error("plain write lost a status bit");

    chk_soft_reset: assert property (
        soft_rst |=> status_reg == `EISM_STATUS_RST)
        else $error("software reset left status bits set");

    chk_test_load: assert property (
        s_test_status_write |=> status_reg == ($past(wr_vec) | $past(set_vec)))
        else $error("test mode write not stored directly");

    chk_mask_gates: assert property (
        (!group1_req && !group0_int_req) |=> !ext_int)
        else $error("masked status raised the interrupt");

    chk_group0_read: assert property (
        (rd_hit && req.addr == `EISM_OFS_STATUS) |=>
            rdata[`EISM_B_GROUP0] == $past(group0_pending))
        else $error("bit 1 does not follow group 0");

    chk_group1_read: assert property (
        (rd_hit && req.addr == `EISM_OFS_STATUS && (|status_reg)) |=>
            rdata[`EISM_B_GROUP1])
        else $error("bit 2 low while status bits are set");

    chk_route_pin: assert property (
        s_routed_pending |=> ext_int)
        else $error("routed extended event missed the pin");

    chk_route_off: assert property (
        (!mask_reg[`EISM_B_GROUP1] && !group0_int_req) |=> !ext_int)
        else $error("pin driven with routing bit clear");

    chk_event_lands: assert property (
        (|set_vec && !soft_rst) |=> (status_reg & $past(set_vec)) == $past(set_vec))
        else $error("event strobe did not set its bit");

    chk_fifo_code: assert property (
        (events.host_fifo_access_error && !soft_rst) |=>
            code_reg == $past(fifo_err_code) ##1 1'b1)
        else $error("fifo error cause not recorded");

    chk_unused_zero: assert property (
        (rd_hit && (req.addr == `EISM_OFS_STATUS || req.addr == `EISM_OFS_MASK)) |=>
            (rdata[0] == 1'b0) && (rdata[13] == 1'b0) && (rdata[15] == 1'b0))
        else $error("unused bit read back as one");

    // a status write, a mask write or software reset in the second cycle may legally drop the request
    chk_req_holds: assert property (
        (s_routed_pending ##1 (s_routed_pending and !(wr_status || wr_mask || soft_rst)))
            |=> ext_int [*2])
        else $error("interrupt dropped while bits still pending");

    chk_mask_survives: assert property (
        (soft_rst && !wr_mask) |=> mask_reg == $past(mask_reg))
        else $error("software reset disturbed the mask");

    chk_group1_idle: assert property (
        (rd_hit && req.addr == `EISM_OFS_STATUS && status_reg == 16'h0000
            && !group1_force_reg) |=> !rdata[`EISM_B_GROUP1])
        else $error("bit 2 high with no status bit set");

    chk_rdata_idle: assert property (
        !rd_hit |=> rdata == 32'h00000000)
        else $error("read data present without a read");

endmodule

//--- rtl/eism_map.svh
// offsets, bit positions, reset values and field layout for the extended event status block
`ifndef EISM_MAP_SVH
`define EISM_MAP_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define EISM_OFS_STATUS 8'h18
`define EISM_OFS_MASK 8'h1C
`define EISM_OFS_DIAGNOSTIC_TEST_REGISTER 8'h30
`define EISM_OFS_FIFO_MISC 8'hF8

// ************************************************************
// status bit positions
// ************************************************************
`define EISM_B_GROUP0 1
`define EISM_B_GROUP1 2
`define EISM_B_ASYNC_AVAIL 3
`define EISM_B_ISO_AVAIL 4
`define EISM_B_TA_AVAIL 5
`define EISM_B_TB_AVAIL 6
`define EISM_B_TA_RELEASE 7
`define EISM_B_TB_RELEASE 8
`define EISM_B_TB_HDR_LOADED 9
`define EISM_B_FIFO_ERR 10
`define EISM_B_OVERLAP_ERR 11
`define EISM_B_ASYNC_PURGE 12
`define EISM_B_ISO_PURGE 14

// ************************************************************
// field masks and reset values
// ************************************************************
`define EISM_EVENT_BITS 16'h5FF8
`define EISM_MASK_BITS 16'h5FFC
`define EISM_STATUS_RST 16'h0000
`define EISM_MASK_RST 16'h0000
`define EISM_DIAGNOSTIC_TEST_REGISTER_RST 1'b0
`define EISM_CODE_RST 4'h0
`define EISM_B_DIAGNOSTIC_TEST_REGISTER_TEST 0
`define EISM_CODE_LSB 1
`define EISM_CODE_MSB 4

`endif

//--- rtl/eism_pkg.sv
// types shared by the extended event status block
package eism_pkg;

    // ************************************************************
    // one-cycle event strobes from the link-layer logic
    // ************************************************************
    typedef struct packed {
        logic iso_rx_purge;              // bit 14
        logic async_rx_purge;            // bit 12
        logic host_overlapping_op_error; // bit 11
        logic host_fifo_access_error;    // bit 10
        logic transport_b_header_loaded; // bit 9
        logic transport_b_release_hit;   // bit 8
        logic transport_a_release_hit;   // bit 7
        logic transport_b_rx_avail;      // bit 6
        logic transport_a_rx_avail;      // bit 5
        logic iso_rx_packet_avail;       // bit 4
        logic async_rx_packet_avail;     // bit 3
    } eism_events_t;

    // ************************************************************
    // register port request
    // ************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } eism_req_t;

endpackage

//--- testbench/eism_src_model.sv
// event source and group-0 summary model beside the status block
`timescale 1ns/100ps

module eism_src_model (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire eism_pkg::eism_events_t fire_ev,
    input wire logic [3:0] fire_code,
    input wire logic g0_pend,
    input wire logic g0_req,
    // towards the block
    output eism_pkg::eism_events_t events,
    output logic [3:0] fifo_err_code,
    output logic group0_pending,
    output logic group0_int_req
);
    // strobes last one cycle, one edge after the bench asks
    always_ff @(posedge clk) begin
        events <= fire_ev;
    end
    // cause code is valid only beside its strobe; otherwise inverted so a stale sample shows
    always_ff @(posedge clk) begin
        if (fire_ev.host_fifo_access_error) begin
            fifo_err_code <= fire_code;
        end else begin
            fifo_err_code <= ~fire_code;
        end
    end
    // group-0 levels, as the group-0 register block would present them
    always_ff @(posedge clk) begin
        group0_pending <= g0_pend;
        group0_int_req <= g0_req;
    end
endmodule

//--- testbench/tb.sv
// self-checking bench for the extended event status block
`timescale 1ns/100ps

// compare, count, report a mismatch at once
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
    // clock, resets, register port
    logic clk;
    logic nrst;
    logic soft_rst;
    eism_pkg::eism_req_t req;
    logic [31:0] rdata;
    // requests to the event model
    eism_pkg::eism_events_t fire_ev;
    logic [3:0] fire_code;
    logic g0_pend;
    logic g0_req;
    // model to design
    eism_pkg::eism_events_t events;
    logic [3:0] fifo_err_code;
    logic group0_pending;
    logic group0_int_req;
    // design outputs
    logic ext_int;
    logic test_en;
    // bookkeeping
    int bad_count;
    int n_checks;
    int b;
    logic [31:0] rv;
    logic [31:0] ev_exp;

    eism_top i_eism_top (.clk(clk), .nrst(nrst), .soft_rst(soft_rst), .req(req), .rdata(rdata),
        .events(events), .fifo_err_code(fifo_err_code), .group0_pending(group0_pending),
        .group0_int_req(group0_int_req), .ext_int(ext_int),
        .direct_register_test_enable(test_en));

    eism_src_model i_eism_src_model (.clk(clk), .fire_ev(fire_ev), .fire_code(fire_code),
        .g0_pend(g0_pend), .g0_req(g0_req), .events(events), .fifo_err_code(fifo_err_code),
        .group0_pending(group0_pending), .group0_int_req(group0_int_req));

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ************************************************************
    // bus and stimulus tasks
    // ************************************************************
    // one-cycle write strobe; a gap cycle follows so a strobe is never set twice per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the taking edge
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 rv = rdata;
        `CHK(rv, exp)
    endtask
    // returns once status is set and the pin has had its edge
    task automatic fire(input eism_pkg::eism_events_t ev, input logic [3:0] code);
        @(posedge clk);
        fire_ev <= ev;
        fire_code <= code;
        @(posedge clk);
        fire_ev <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // verdict and end of run
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog well past the expected run
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        nrst = 1'b0;
        soft_rst = 1'b0;
        req = '0;
        fire_ev = '0;
        fire_code = 4'h0;
        g0_pend = 1'b0;
        g0_req = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        chk_rd(8'h18, 32'h0);
        chk_rd(8'h1C, 32'h0);
        `CHK(ext_int, 1'b0)
        // each strobe sets its own bit; mask is zero so the pin stays low
        for (int k = 0; k < 11; k++) begin
            b = (k < 10) ? k + 3 : 14;
            ev_exp = (32'h1 << b) | 32'h4;
            fire(11'h1 << k, 4'h7);
            `CHK(ext_int, 1'b0)
            chk_rd(8'h18, ev_exp);
            if (b == 10) chk_rd(8'hF8, 32'hE);
            wr(8'h18, 32'h4);
            chk_rd(8'h18, ev_exp);
            wr(8'h18, 32'h1 << b);
            chk_rd(8'h18, 32'h0);
        end
        // unused bits stay zero; request holds until cleared
        wr(8'h1C, 32'hFFFFFFFF);
        chk_rd(8'h1C, 32'h5FFC);
        fire('1, 4'h0);
        `CHK(ext_int, 1'b1)
        chk_rd(8'h18, 32'h5FFC);
        repeat (5) @(posedge clk);
        `CHK(ext_int, 1'b1)
        wr(8'h18, 32'hFFFFFFFF);
        chk_rd(8'h18, 32'h0);
        `CHK(ext_int, 1'b0)
        // routing bit and per-bit mask
        wr(8'h1C, 32'h8);
        fire(11'h1, 4'h0);
        `CHK(ext_int, 1'b0)
        wr(8'h1C, 32'hC);
        @(posedge clk);
        #1 `CHK(ext_int, 1'b1)
        wr(8'h1C, 32'h4);
        @(posedge clk);
        #1 `CHK(ext_int, 1'b0)
        @(posedge clk);
        g0_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK(ext_int, 1'b1)
        g0_pend <= 1'b1;
        g0_req <= 1'b0;
        chk_rd(8'h18, 32'hE);
        g0_pend <= 1'b0;
        wr(8'h18, 32'hFFFFFFFF);
        chk_rd(8'h18, 32'h0);
        // direct test access, then leaving it
        wr(8'h30, 32'h1);
        chk_rd(8'h30, 32'h1);
        `CHK(test_en, 1'b1)
        wr(8'h18, 32'hFFFFFFFF);
        chk_rd(8'h18, 32'h5FFC);
        wr(8'h30, 32'h0);
        wr(8'h18, 32'hFFFFFFFF);
        chk_rd(8'h18, 32'h0);
        // soft reset clears status, mask survives
        fire('1, 4'h0);
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        chk_rd(8'h18, 32'h0);
        chk_rd(8'h1C, 32'h4);
        chk_rd(8'h40, 32'h0);
        end_sim();
    end
endmodule
